/* tb/startup_softstart_power_good_sequencer_tb.sv */
// Self-checking bench for the start-up, soft-start and power-good sequencer
`timescale 1ns/10ps
module startup_softstart_power_good_sequencer_tb;
    localparam int MS = 20;
    localparam logic [7:0] RAMP_TBL [10] = '{8'h05, 8'h0a, 8'h02, 8'h05, 8'h0a, 8'h14, 8'h02, 8'h05, 8'h0a, 8'h14};
    localparam logic [7:0] DLY_TBL [3] = '{8'h05, 8'h0a, 8'h14};
    localparam logic [7:0] STRAP_TBL [3] = '{8'h02, 8'h05, 8'h0a};
    localparam logic [11:0] OFS [5] = '{12'h006, 12'h007, 12'hffc, 12'hffb, 12'h007};
    localparam logic [4:0] PG_EXP = 5'h15;
    logic core_clk = 1'b0, sys_rst = 1'b1, enable_pin = 1'b1, restore_req = 1'b0, nvm_valid = 1'b0;
    logic host_cfg_wr = 1'b0, precise_delay_mode = 1'b0, fault_in = 1'b0;
    logic [7:0] nvm_delay_ms = 8'h00, nvm_ramp_ms = 8'h00, host_delay_ms = 8'h00, host_ramp_ms = 8'h00;
    logic [7:0] host_pg_hi_pct = 8'h0f, host_pg_lo_pct = 8'h0a;
    logic [15:0] host_pg_delay_us = 16'h0001;
    logic [1:0] ss_pin_level = 2'h0;
    logic [1:0] undervoltage_lockout_threshold;
    logic [1:0] uv_exp = 2'h2;
    logic [4:0] ss_pin_row = 5'h00;
    logic [11:0] vout_target = 12'h028, vout_offset = 12'h000, vout_meas, ramp_ref;
    logic host_ready, delay_active, ramp_active, power_good_output;
    int num_errors = 0;
    int compares = 0;
    int seed = 32'h1ef3;
    int n;
    startup_sequencer #(.MS_CYCLES(MS), .NVM_CHECK_CYCLES(50), .US_CYCLES(2)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .enable_pin(enable_pin), .restore_req(restore_req),
        .nvm_valid(nvm_valid), .nvm_delay_ms(nvm_delay_ms), .nvm_ramp_ms(nvm_ramp_ms),
        .ss_pin_level(ss_pin_level), .ss_pin_row(ss_pin_row), .host_cfg_wr(host_cfg_wr),
        .host_delay_ms(host_delay_ms), .host_ramp_ms(host_ramp_ms), .host_pg_hi_pct(host_pg_hi_pct),
        .host_pg_lo_pct(host_pg_lo_pct), .host_pg_delay_us(host_pg_delay_us),
        .precise_delay_mode(precise_delay_mode), .vout_target(vout_target), .vout_meas(vout_meas),
        .fault_in(fault_in), .host_ready(host_ready), .delay_active(delay_active), .ramp_active(ramp_active),
        .ramp_ref(ramp_ref), .undervoltage_lockout_threshold(undervoltage_lockout_threshold),
        .power_good_output(power_good_output));
    vout_plant i_plant (.core_clk(core_clk), .ramp_ref(ramp_ref), .vout_offset(vout_offset), .vout_meas(vout_meas));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic end_of_test();
        $display("Mismatches %0d, comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: saw %h, want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic in_range(input int v, input int lo, input int hi, input string what);
        check(16'(v >= lo && v <= hi), 16'h0001, what);
    endtask : in_range
    function automatic logic pick(input int sel);
        case (sel)
            0: pick = host_ready;
            1: pick = delay_active;
            2: pick = ramp_active;
            default: pick = power_good_output;
        endcase
    endfunction : pick
    // Bounded wait, so a stuck state shows up as a count out of range
    task automatic wait_for(input int sel, input logic v, input int lo, input int hi, input string what);
        n = 0;
        while (pick(sel) !== v && n <= hi) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        in_range(n, lo, hi, what);
    endtask : wait_for
    task automatic host_wr(input logic [7:0] dly, input logic [7:0] rmp, input logic [7:0] hi, input logic [15:0] pgd);
        @(posedge core_clk);
        host_cfg_wr <= 1'b1;
        host_delay_ms <= dly;
        host_ramp_ms <= rmp;
        host_pg_hi_pct <= hi;
        host_pg_delay_us <= pgd;
        @(posedge core_clk);
        host_cfg_wr <= 1'b0;
    endtask : host_wr
    task automatic run_seq(input int kind, input int pgd);
        logic [7:0] d, r;
        logic [11:0] prev;
        int need;
        @(posedge core_clk);
        enable_pin <= (kind != 0);
        d = (ss_pin_level == 2'h3) ? DLY_TBL[ss_pin_row % 3] : STRAP_TBL[ss_pin_level];
        r = (ss_pin_level == 2'h3) ? RAMP_TBL[ss_pin_row / 3] : d;
        // Threshold only changes at a pin load, so a plain rerun keeps the last one
        if (kind != 0) uv_exp = (ss_pin_level == 2'h3) ? 2'(ss_pin_row / 10) : 2'h2;
        if (nvm_valid) begin
            d = nvm_delay_ms;
            r = nvm_ramp_ms;
        end
        if (kind == 0) begin
            d = host_delay_ms;
            r = host_ramp_ms;
        end
        need = ((d < 8'h02) ? 2 : int'(d)) + (precise_delay_mode ? 0 : 1);
        repeat (4) @(posedge core_clk);
        if (kind != 0) begin
            sys_rst <= (kind == 1);
            restore_req <= (kind == 2);
            repeat (5) @(posedge core_clk);
            sys_rst <= 1'b0;
            restore_req <= 1'b0;
            // Write during the check must be dropped, or the pg delay shrinks
            host_wr(8'h00, 8'h00, 8'h01, 16'h0001);
            #1;
            check(16'({host_ready, delay_active}), 16'h0000, "busy during check");
            wait_for(0, 1'b1, 46, 54, "ready after check");
        end
        @(posedge core_clk);
        ss_pin_level <= 2'($random(seed));
        ss_pin_row <= 5'($random(seed));
        enable_pin <= 1'b1;
        wait_for(1, 1'b1, 0, 4, "delay start");
        wait_for(1, 1'b0, (need - (precise_delay_mode ? 0 : 1)) * MS - 2, need * MS + 2, "delay length");
        if (r == 8'h00) begin
            check(16'(ramp_ref), 16'(vout_target), "no ramp limit");
        end else begin
            check(16'(ramp_active), 16'h0001, "ramp start");
            prev = 12'h000;
            n = 0;
            while (ramp_active === 1'b1 && n < 2000) begin
                if (ramp_ref < prev) check(16'(ramp_ref), 16'(prev), "ramp fell");
                prev = ramp_ref;
                @(posedge core_clk);
                #1;
                n++;
            end
            in_range(n, r * MS - r * MS / 8 - 4, r * MS + 4, "ramp time");
            check(16'(ramp_ref), 16'(vout_target), "ramp end");
        end
        wait_for(3, 1'b1, pgd * 2 - 3, pgd * 2 + 3, "pg delay");
        check(16'(undervoltage_lockout_threshold), 16'(uv_exp), "threshold");
    endtask : run_seq
    initial begin
        run_seq(1, 1000);
        @(posedge core_clk);
        fault_in <= 1'b1;
        repeat (1) @(posedge core_clk);
        #1;
        check(16'(power_good_output), 16'h0000, "pg with fault");
        @(posedge core_clk);
        fault_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            vout_offset <= OFS[i];
            if (i == 4) host_wr(8'h00, 8'h00, 8'h14, 16'h0005);
            repeat (2020) @(posedge core_clk);
            #1;
            check(16'(power_good_output), 16'(PG_EXP[i]), "pg window");
        end
        // Random targets below would fall outside the window with an offset left on
        vout_offset <= 12'h000;
        run_seq(0, 5);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            ss_pin_level <= 2'($random(seed));
            ss_pin_row <= 5'(($random(seed) & 32'h7fffffff) % 30);
            precise_delay_mode <= 1'($random(seed));
            nvm_valid <= (i % 4 == 3);
            nvm_delay_ms <= 8'($random(seed) & 3);
            nvm_ramp_ms <= 8'(($random(seed) & 1) * 3);
            vout_target <= 12'(($random(seed) & 31) + 1);
            run_seq(2, 5);
        end
        end_of_test();
    end
    // Whole run is near 15k cycles; this limit only trips on a hang
    initial begin
        #450000;
        num_errors++;
        end_of_test();
    end
endmodule : startup_softstart_power_good_sequencer_tb

/* tb/vout_plant.sv */
// Output stage stand-in: measured output follows the ramp reference
`timescale 1ns/10ps
module vout_plant (
    input wire logic core_clk,
    input wire logic [11:0] ramp_ref,
    input wire logic [11:0] vout_offset,
    output logic [11:0] vout_meas
);
    // One cycle of lag, as a real loop is never faster than its reference
    always_ff @(posedge core_clk) begin
        vout_meas <= ramp_ref + vout_offset;
    end
endmodule : vout_plant

/* verilog/ms_tick_timer.sv */
// Millisecond tick generator with restart for the precise delay mode
`timescale 1ns/10ps
module ms_tick_timer #(
    parameter int MS_CYCLES = seq_pkg::MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic restart,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tmr_t;

    tmr_t r_r;
    tmr_t r_nxt;

    always_comb begin
        r_nxt = r_r;
        r_nxt.tick = 1'b0;
        if (restart) begin
            r_nxt.cnt = 32'h0;
        end else if (r_r.cnt >= 32'(MS_CYCLES - 1)) begin
            r_nxt.cnt = 32'h0;
            r_nxt.tick = 1'b1;
        end else begin
            r_nxt.cnt = r_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign tick = r_r.tick;
endmodule : ms_tick_timer

/* verilog/seq_pkg.sv */
// Constants and types shared by the start-up sequencer files
package seq_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 200;
    localparam int MS_IN_US = 1000;
    localparam int MS_CYCLES = MS_IN_US * CLK_MHZ;
    localparam int US_CYCLES = CLK_MHZ;
    localparam int NVM_CHECK_MS = 5;
    localparam int NVM_CHECK_CYCLES = NVM_CHECK_MS * MS_CYCLES;
    localparam logic [7:0] MIN_DELAY_MS = 8'h02;
    // ****************************************************************
    // Soft-start pin levels and strap settings
    // ****************************************************************
    localparam logic [1:0] SS_LOW = 2'h0;
    localparam logic [1:0] SS_OPEN = 2'h1;
    localparam logic [1:0] SS_HIGH = 2'h2;
    localparam logic [1:0] SS_RES = 2'h3;
    localparam logic [7:0] STRAP_LOW_MS = 8'h02;
    localparam logic [7:0] STRAP_OPEN_MS = 8'h05;
    localparam logic [7:0] STRAP_HIGH_MS = 8'h0a;
    localparam logic [7:0] RES_DLY_A_MS = 8'h05;
    localparam logic [7:0] RES_DLY_B_MS = 8'h0a;
    localparam logic [7:0] RES_DLY_C_MS = 8'h14;
    localparam logic [4:0] RES_ROWS = 5'h1e;
    localparam logic [4:0] RES_ROWS_PER_UNDERVOLTAGE_LOCKOUT_THRESHOLD = 5'h0a;
    // Ramp time per group of three resistor rows, group 0 last (lowest byte)
    localparam logic [79:0] RES_RAMP_MS = {8'h14, 8'h0a, 8'h05, 8'h02, 8'h14,
                                           8'h0a, 8'h05, 8'h02, 8'h0a, 8'h05};
    // ****************************************************************
    // Undervoltage threshold selections
    // ****************************************************************
    localparam logic [1:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_4V5 = 2'h0;
    localparam logic [1:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_5V5 = 2'h1;
    localparam logic [1:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_7V5 = 2'h2;
    // ****************************************************************
    // Power-good defaults
    // ****************************************************************
    localparam logic [7:0] PG_HI_PCT_RST = 8'h0f;
    localparam logic [7:0] PG_LO_PCT_RST = 8'h0a;
    localparam logic [15:0] PG_DELAY_US_RST = 16'h03e8;
    localparam logic [7:0] PCT_FULL = 8'h64;
    // ****************************************************************
    // Sequencer states, Gray along the start-up path
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_MEMCHK = 3'h0,
        ST_PINCHK = 3'h1,
        ST_READY = 3'h3,
        ST_DELAY = 3'h2,
        ST_RAMP = 3'h6,
        ST_ON = 3'h7
    } seq_state_t;
endpackage : seq_pkg

/* verilog/ss_pin_decode.sv */
// Decode of the soft-start pin strap level or resistor row
`timescale 1ns/10ps
module ss_pin_decode (
    input wire logic [1:0] ss_level,
    input wire logic [4:0] ss_row,
    output logic [7:0] delay_ms,
    output logic [7:0] ramp_ms,
    output logic [1:0] undervoltage_lockout_threshold_sel
);
    logic [4:0] grp;
    logic [4:0] col;

    always_comb begin
        grp = ss_row / 5'h03;
        col = ss_row - grp * 5'h03;
        delay_ms = seq_pkg::STRAP_LOW_MS;
        ramp_ms = seq_pkg::STRAP_LOW_MS;
        undervoltage_lockout_threshold_sel = seq_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_7V5;
        unique case (ss_level)
            seq_pkg::SS_LOW: begin
                delay_ms = seq_pkg::STRAP_LOW_MS;
                ramp_ms = seq_pkg::STRAP_LOW_MS;
            end
            seq_pkg::SS_OPEN: begin
                delay_ms = seq_pkg::STRAP_OPEN_MS;
                ramp_ms = seq_pkg::STRAP_OPEN_MS;
            end
            seq_pkg::SS_HIGH: begin
                delay_ms = seq_pkg::STRAP_HIGH_MS;
                ramp_ms = seq_pkg::STRAP_HIGH_MS;
            end
            seq_pkg::SS_RES: begin
                // Rows past the table clamp to the last row
                if (ss_row >= seq_pkg::RES_ROWS) begin
                    grp = 5'h09;
                    col = 5'h02;
                end
                delay_ms = (col == 5'h0) ? seq_pkg::RES_DLY_A_MS :
                           (col == 5'h1) ? seq_pkg::RES_DLY_B_MS : seq_pkg::RES_DLY_C_MS;
                ramp_ms = seq_pkg::RES_RAMP_MS[grp * 8 +: 8];
                undervoltage_lockout_threshold_sel = (grp * 5'h03 + col < seq_pkg::RES_ROWS_PER_UNDERVOLTAGE_LOCKOUT_THRESHOLD) ? seq_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_4V5 :
                           (grp * 5'h03 + col < 5'(2 * seq_pkg::RES_ROWS_PER_UNDERVOLTAGE_LOCKOUT_THRESHOLD)) ? seq_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_5V5 :
                           seq_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_7V5;
            end
        endcase
    end
endmodule : ss_pin_decode

/* verilog/startup_sequencer.sv */
// Start-up, soft-start delay and ramp, and power-good sequencer
`timescale 1ns/10ps
module startup_sequencer #(
    parameter int MS_CYCLES = seq_pkg::MS_CYCLES,
    parameter int NVM_CHECK_CYCLES = seq_pkg::NVM_CHECK_CYCLES,
    parameter int US_CYCLES = seq_pkg::US_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic enable_pin,
    input wire logic restore_req,
    input wire logic nvm_valid,
    input wire logic [7:0] nvm_delay_ms,
    input wire logic [7:0] nvm_ramp_ms,
    input wire logic [1:0] ss_pin_level,
    input wire logic [4:0] ss_pin_row,
    input wire logic host_cfg_wr,
    input wire logic [7:0] host_delay_ms,
    input wire logic [7:0] host_ramp_ms,
    input wire logic [7:0] host_pg_hi_pct,
    input wire logic [7:0] host_pg_lo_pct,
    input wire logic [15:0] host_pg_delay_us,
    input wire logic precise_delay_mode,
    input wire logic [11:0] vout_target,
    input wire logic [11:0] vout_meas,
    input wire logic fault_in,
    output logic host_ready,
    output logic delay_active,
    output logic ramp_active,
    output logic [11:0] ramp_ref,
    output logic [1:0] undervoltage_lockout_threshold,
    output logic power_good_output
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        seq_pkg::seq_state_t st;
        logic en_s1;
        logic en_s2;
        logic [1:0] lvl_s1;
        logic [1:0] lvl_s2;
        logic [4:0] row_s1;
        logic [4:0] row_s2;
        logic [31:0] cnt;
        logic [7:0] delay_ms;
        logic [7:0] ramp_ms;
        logic [1:0] undervoltage_lockout_threshold_sel;
        logic [7:0] pg_hi_pct;
        logic [7:0] pg_lo_pct;
        logic [15:0] pg_delay_us;
        logic [7:0] tick_cnt;
        logic [31:0] ramp_acc;
        logic [11:0] ref_v;
        logic [31:0] pg_cnt;
        logic pg;
        logic ready;
        logic delay_act;
        logic ramp_act;
    } seq_t;

    seq_t r_r;
    seq_t r_nxt;
    logic tick;
    logic tmr_restart;
    logic [7:0] pin_delay_ms;
    logic [7:0] pin_ramp_ms;
    logic [1:0] pin_undervoltage_lockout_threshold;
    logic [7:0] eff_delay;
    logic [8:0] need_ticks;
    logic [31:0] ramp_cycles;
    logic [31:0] acc_sum;
    logic [31:0] pg_total;
    logic [31:0] meas_x100;
    logic [31:0] lo_lim;
    logic [31:0] hi_lim;
    logic in_window;
    logic pg_ok;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    ss_pin_decode u_ss_decode (
        .ss_level(r_r.lvl_s2),
        .ss_row(r_r.row_s2),
        .delay_ms(pin_delay_ms),
        .ramp_ms(pin_ramp_ms),
        .undervoltage_lockout_threshold_sel(pin_undervoltage_lockout_threshold)
    );

    // Precise mode restarts the tick phase on enable; otherwise the phase is free running
    assign tmr_restart = (r_r.st == seq_pkg::ST_READY) && r_r.en_s2 && precise_delay_mode;

    ms_tick_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_ms_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .restart(tmr_restart),
        .tick(tick)
    );

    // ****************************************************************
    // Derived terms
    // ****************************************************************
    always_comb begin
        eff_delay = (r_r.delay_ms < seq_pkg::MIN_DELAY_MS) ? seq_pkg::MIN_DELAY_MS : r_r.delay_ms;
        // Free-running phase can lose up to one tick, so one is added
        need_ticks = {1'b0, eff_delay} + (precise_delay_mode ? 9'h0 : 9'h1);
        ramp_cycles = 32'(r_r.ramp_ms) * 32'(MS_CYCLES);
        acc_sum = r_r.ramp_acc + 32'(vout_target);
        pg_total = 32'(r_r.pg_delay_us) * 32'(US_CYCLES);
        meas_x100 = 32'(vout_meas) * 32'(seq_pkg::PCT_FULL);
        lo_lim = 32'(vout_target) * 32'(seq_pkg::PCT_FULL - r_r.pg_lo_pct);
        hi_lim = 32'(vout_target) * (32'(seq_pkg::PCT_FULL) + 32'(r_r.pg_hi_pct));
        in_window = (meas_x100 >= lo_lim) && (meas_x100 <= hi_lim);
        pg_ok = (r_r.st == seq_pkg::ST_ON) && in_window && !fault_in;
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        r_nxt = r_r;
        r_nxt.en_s1 = enable_pin;
        r_nxt.en_s2 = r_r.en_s1;
        r_nxt.lvl_s1 = ss_pin_level;
        r_nxt.lvl_s2 = r_r.lvl_s1;
        r_nxt.row_s1 = ss_pin_row;
        r_nxt.row_s2 = r_r.row_s1;
        if (r_r.ready && host_cfg_wr) begin
            r_nxt.delay_ms = host_delay_ms;
            r_nxt.ramp_ms = host_ramp_ms;
            r_nxt.pg_hi_pct = host_pg_hi_pct;
            r_nxt.pg_lo_pct = host_pg_lo_pct;
            r_nxt.pg_delay_us = host_pg_delay_us;
        end
        unique case (r_r.st)
            seq_pkg::ST_MEMCHK: begin
                // Enable and host writes have no effect here
                if (r_r.cnt >= 32'(NVM_CHECK_CYCLES - 1)) begin
                    r_nxt.st = seq_pkg::ST_PINCHK;
                    r_nxt.cnt = 32'h0;
                end else begin
                    r_nxt.cnt = r_r.cnt + 32'h1;
                end
            end
            seq_pkg::ST_PINCHK: begin
                // Stored values win over the pin; threshold comes from the pin
                r_nxt.delay_ms = nvm_valid ? nvm_delay_ms : pin_delay_ms;
                r_nxt.ramp_ms = nvm_valid ? nvm_ramp_ms : pin_ramp_ms;
                r_nxt.undervoltage_lockout_threshold_sel = pin_undervoltage_lockout_threshold;
                r_nxt.st = seq_pkg::ST_READY;
                r_nxt.ready = 1'b1;
            end
            seq_pkg::ST_READY: begin
                if (r_r.en_s2) begin
                    r_nxt.st = seq_pkg::ST_DELAY;
                    r_nxt.tick_cnt = 8'h0;
                    r_nxt.delay_act = 1'b1;
                end
            end
            seq_pkg::ST_DELAY: begin
                if (tick) begin
                    r_nxt.tick_cnt = r_r.tick_cnt + 8'h1;
                    if ({1'b0, r_r.tick_cnt} + 9'h1 >= need_ticks) begin
                        r_nxt.delay_act = 1'b0;
                        r_nxt.ramp_acc = 32'h0;
                        if (r_r.ramp_ms == 8'h0) begin
                            r_nxt.st = seq_pkg::ST_ON;
                            r_nxt.ref_v = vout_target;
                        end else begin
                            r_nxt.st = seq_pkg::ST_RAMP;
                            r_nxt.ramp_act = 1'b1;
                        end
                    end
                end
            end
            seq_pkg::ST_RAMP: begin
                // One step at most per cycle since the ramp span exceeds the target code
                if (r_r.ref_v >= vout_target) begin
                    r_nxt.st = seq_pkg::ST_ON;
                    r_nxt.ramp_act = 1'b0;
                end else if (acc_sum >= ramp_cycles) begin
                    r_nxt.ramp_acc = acc_sum - ramp_cycles;
                    r_nxt.ref_v = r_r.ref_v + 12'h1;
                end else begin
                    r_nxt.ramp_acc = acc_sum;
                end
            end
            seq_pkg::ST_ON: begin
                r_nxt.ref_v = vout_target;
            end
            default: begin
                r_nxt.st = seq_pkg::ST_MEMCHK;
            end
        endcase
        if (r_r.st != seq_pkg::ST_MEMCHK && r_r.st != seq_pkg::ST_PINCHK
            && r_r.st != seq_pkg::ST_READY && !r_r.en_s2) begin
            r_nxt.st = seq_pkg::ST_READY;
            r_nxt.ref_v = 12'h0;
            r_nxt.delay_act = 1'b0;
            r_nxt.ramp_act = 1'b0;
        end
        // Power-good: drop at once, rise only after the full delay
        if (!pg_ok) begin
            r_nxt.pg = 1'b0;
            r_nxt.pg_cnt = 32'h0;
        end else if (!r_r.pg) begin
            if (r_r.pg_cnt + 32'h1 >= pg_total) begin
                r_nxt.pg = 1'b1;
            end else begin
                r_nxt.pg_cnt = r_r.pg_cnt + 32'h1;
            end
        end
        if (restore_req) begin
            r_nxt.st = seq_pkg::ST_MEMCHK;
            r_nxt.cnt = 32'h0;
            r_nxt.ready = 1'b0;
            r_nxt.ref_v = 12'h0;
            r_nxt.delay_act = 1'b0;
            r_nxt.ramp_act = 1'b0;
            r_nxt.pg = 1'b0;
            r_nxt.pg_cnt = 32'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r_r <= '0;
            r_r.st <= seq_pkg::ST_MEMCHK;
            r_r.pg_hi_pct <= seq_pkg::PG_HI_PCT_RST;
            r_r.pg_lo_pct <= seq_pkg::PG_LO_PCT_RST;
            r_r.pg_delay_us <= seq_pkg::PG_DELAY_US_RST;
            r_r.undervoltage_lockout_threshold_sel <= seq_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_7V5;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign host_ready = r_r.ready;
    assign delay_active = r_r.delay_act;
    assign ramp_active = r_r.ramp_act;
    assign ramp_ref = r_r.ref_v;
    assign undervoltage_lockout_threshold = r_r.undervoltage_lockout_threshold_sel;
    assign power_good_output = r_r.pg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_memchk_len;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.st == seq_pkg::ST_PINCHK && $past(r_r.st) == seq_pkg::ST_MEMCHK) |-> $past(r_r.cnt) == 32'(NVM_CHECK_CYCLES - 1);
    endproperty
    a_memchk_len: assert property (p_memchk_len) else $error("memory check left early");

    property p_pin_then_ready;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.st == seq_pkg::ST_PINCHK && !restore_req) |=> (r_r.st == seq_pkg::ST_READY) && r_r.ready;
    endproperty
    a_pin_then_ready: assert property (p_pin_then_ready) else $error("pin load not followed by ready");

    property p_no_write_in_check;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.st == seq_pkg::ST_MEMCHK) |=> $stable(r_r.pg_delay_us) && $stable(r_r.pg_hi_pct);
    endproperty
    a_no_write_in_check: assert property (p_no_write_in_check) else $error("host write taken during check");

    property p_check_ignores_en;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.st == seq_pkg::ST_MEMCHK) |=> (r_r.st == seq_pkg::ST_MEMCHK || r_r.st == seq_pkg::ST_PINCHK) && !r_r.ready;
    endproperty
    a_check_ignores_en: assert property (p_check_ignores_en) else $error("enable acted during check");

    property p_restore;
        @(posedge core_clk) disable iff (sys_rst)
        restore_req |=> (r_r.st == seq_pkg::ST_MEMCHK) && (r_r.cnt == 32'h0) && !r_r.pg && (r_r.ref_v == 12'h0);
    endproperty
    a_restore: assert property (p_restore) else $error("restore did not restart check");

    property p_min_delay;
        @(posedge core_clk) disable iff (sys_rst)
        ($past(r_r.st) == seq_pkg::ST_DELAY && r_r.st != seq_pkg::ST_DELAY && r_r.st != seq_pkg::ST_READY
         && r_r.st != seq_pkg::ST_MEMCHK) |-> ({1'b0, $past(r_r.tick_cnt)} + 9'h1 >= {1'b0, seq_pkg::MIN_DELAY_MS});
    endproperty
    a_min_delay: assert property (p_min_delay) else $error("delay shorter than minimum");

    property p_monotonic;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.st == seq_pkg::ST_RAMP && r_r.en_s2 && !restore_req) |=> r_r.ref_v >= $past(r_r.ref_v);
    endproperty
    a_monotonic: assert property (p_monotonic) else $error("ramp not monotonic");

    property p_no_ramp;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.st == seq_pkg::ST_ON && $past(r_r.st) == seq_pkg::ST_DELAY) |-> $past(r_r.ramp_ms) == 8'h0;
    endproperty
    a_no_ramp: assert property (p_no_ramp) else $error("ramp skipped with nonzero ramp time");

    property p_pg_cause;
        @(posedge core_clk) disable iff (sys_rst)
        r_r.pg |-> $past(pg_ok);
    endproperty
    a_pg_cause: assert property (p_pg_cause) else $error("power-good without valid conditions");

    property p_pg_delay;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(r_r.pg) |-> ($past(r_r.pg_cnt) + 32'h1 >= $past(pg_total));
    endproperty
    a_pg_delay: assert property (p_pg_delay) else $error("power-good rose before delay");

    property p_pg_drop;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.pg && !pg_ok) |=> !r_r.pg;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("power-good held after violation");

    property p_pin_frozen;
        @(posedge core_clk) disable iff (sys_rst)
        (r_r.ready && !restore_req) |=> $stable(r_r.undervoltage_lockout_threshold_sel);
    endproperty
    a_pin_frozen: assert property (p_pin_frozen) else $error("pin setting changed after load");

    c_reach_on: cover property (@(posedge core_clk) disable iff (sys_rst) r_r.st == seq_pkg::ST_ON);
    c_pg_rise: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(r_r.pg));
    c_restore_on: cover property (@(posedge core_clk) disable iff (sys_rst) restore_req && r_r.st == seq_pkg::ST_ON);
endmodule : startup_sequencer
